// [rpt_pkg.sv]
// Purpose: Shared constants and types for the repeater path controller.
// Assumes: 125 MHz system clock, synchronous active-high reset.
// Notes: Times are kept in their own units; cycle counts derive from them.
package rpt_pkg;

  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned INIT_WAIT_MS = 10;
  localparam int unsigned IDLE_TIMEOUT_US = 3000;
  localparam int unsigned DETACH_HOLD_US = 3000;
  localparam int unsigned HOST_SOF_GAP_NS = 5000;
  localparam int unsigned HOST_HS_QUIET_US = 2950;
  localparam int unsigned SYNC_BITS = 32;
  localparam int unsigned SOF_EOP_BITS = 40;
  localparam int unsigned CNT_W = 24;

  // Derived cycle counts; the controller ones are shortened in simulation by top-level parameters.
  localparam int unsigned INIT_WAIT_CYC = INIT_WAIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned DETACH_HOLD_CYC = DETACH_HOLD_US * CLK_MHZ;
  localparam int unsigned HOST_SOF_GAP_CYC = (HOST_SOF_GAP_NS + 7) / 8 + 1;
  localparam int unsigned HOST_HS_QUIET_CYC = HOST_HS_QUIET_US * CLK_MHZ;

  // Encoded line states reported by the analog front end.
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_J = 2'h1;
  localparam logic [1:0] LINE_K = 2'h2;
  localparam logic [1:0] LINE_SE1 = 2'h3;

  // Path selection seen at the pins.
  localparam logic [1:0] PATH_OFF = 2'h0;
  localparam logic [1:0] PATH_SWITCH = 2'h1;
  localparam logic [1:0] PATH_RETIME = 2'h2;

  typedef enum logic [3:0] {
    ST_RESET, ST_INITIAL, ST_DISCONNECT, ST_FSLS, ST_CHIRP, ST_HS,
    ST_SUSPEND, ST_RESUME, ST_DETACH
  } path_state_t;

endpackage

// [rpt_link_if.sv]
`timescale 1ns/1ns
// Purpose: Joins the repeater controller and its host-side partner.
// Assumes: Single clock; all signals synchronous to clk_sys.
// Notes: Line states are those the analog front end would report.
interface rpt_link_if;
  logic enable;
  logic detach_hold;
  logic [1:0] inner_line;
  logic [1:0] outer_line;
  logic inner_hs_activity;
  logic outer_hs_activity;
  logic inner_sof;
  logic outer_sof;
  logic disconnect_flag;
  logic [1:0] path_sel;
  logic outer_port_oe;
  logic inner_discon_en;
  logic outer_discon_en;
  logic [3:0] state_code;

  modport repeater (
    input enable, detach_hold, inner_line, outer_line, inner_hs_activity,
    outer_hs_activity, inner_sof, outer_sof, disconnect_flag,
    output path_sel, outer_port_oe, inner_discon_en, outer_discon_en,
    state_code
  );
  modport partner (
    output enable, detach_hold, inner_line, outer_line, inner_hs_activity,
    outer_hs_activity, inner_sof, outer_sof, disconnect_flag,
    input path_sel, outer_port_oe, inner_discon_en, outer_discon_en,
    state_code
  );
endinterface

// [rpt_path_ctrl.sv]
// What this block does
// R1: Reset holds both paths off, outer floating.
// R2: Enable high in disconnect enters full/low-speed.
// R3: Full/low-speed waits out the whole chirp.
// R4: SE0 after chirp enters HS, re-timing path.
// R5: Host waits over 5us before first SOF.
// R6: HS re-times both directions, 32-bit SYNC.
// R7: Host schedules around added re-timing delay.
// R8: Disconnect detect only on non-SOF port.
// R9: 3ms without HS falls back to passthrough.
// R10: Nobody sends HS after 2.95ms quiet.
// R11: After fallback: SE0 reset, J suspend.
// R12: Suspended: SE0 reset, K starts resume.
// R13: SE0 after K during resume re-enters HS.
// R14: Host waits over 5us after resume.
// R15: Resume restores previous disconnect-detect port.
// R16: Detach on SOF EOP leaves HS.
// R17: After detach, route through passthrough.
// R18: Detach-hold floats outer port 3ms first.
// R19: Host may drop enable after detach.
// R20: Enable low enters disconnect, passthrough kept.
// R21: Enable high again accepts new attach.
// R22: Reset release reaches disconnect after 10ms.
// R23: Front-end flags synchronised before use.
//
// Purpose: Path and state controller of a high-speed re-timing repeater.
// Assumes: Front-end flags may be asynchronous and are double-flopped.
// Notes: The re-timing datapath itself is outside; path_sel steers it.
`timescale 1ns/1ns
module rpt_path_ctrl
  import rpt_pkg::*;
#(
  parameter int unsigned INIT_CYC = rpt_pkg::INIT_WAIT_CYC,
  parameter int unsigned IDLE_CYC = rpt_pkg::IDLE_TIMEOUT_CYC,
  parameter int unsigned HOLD_CYC = rpt_pkg::DETACH_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic active_low_chip_reset_n,
  rpt_link_if.repeater link
);
  import rpt_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 11;
  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;
  wire [SW-1:0] raw_in = {link.enable, link.detach_hold, link.inner_line,
    link.outer_line, link.inner_hs_activity, link.outer_hs_activity,
    link.inner_sof, link.outer_sof, link.disconnect_flag};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in; // R23
      sync_b <= sync_a; // R23
    end
  end

  wire en_s = sync_b[10];
  wire hold_s = sync_b[9];
  wire [1:0] in_line = sync_b[8:7];
  wire [1:0] out_line = sync_b[6:5];
  wire hs_act = sync_b[4] | sync_b[3];
  wire in_sof = sync_b[2];
  wire out_sof = sync_b[1];
  wire discon = sync_b[0];

  // ----------------------------------------------------------------
  // State and timer
  // ----------------------------------------------------------------
  path_state_t state;
  path_state_t next_state;
  logic [CNT_W-1:0] timer;
  logic sof_on_outer;
  logic chirp_seen;
  logic [1:0] prev_out;

  wire chip_in_reset = ~active_low_chip_reset_n;
  wire init_done = (timer >= CNT_W'(INIT_CYC - 1));
  wire idle_done = (timer >= CNT_W'(IDLE_CYC - 1));
  wire hold_done = (timer >= CNT_W'(HOLD_CYC - 1));
  wire in_hs = (state == ST_HS);
  wire in_se0 = (in_line == LINE_SE0);
  wire out_se0 = (out_line == LINE_SE0);
  wire chirp_tone = (in_line == LINE_K) || (in_line == LINE_J);
  // Resume ends only on an SE0 that directly follows K, not on any SE0.
  wire k_then_se0 = out_se0 && (prev_out == LINE_K);
  wire disc_port_flag = discon; // R8

  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: next_state = ST_INITIAL;
      ST_INITIAL: if (init_done) next_state = ST_DISCONNECT; // R22
      ST_DISCONNECT: if (en_s) next_state = ST_FSLS; // R2 R21
      ST_FSLS: if (in_se0) next_state = ST_CHIRP;
      ST_CHIRP: begin
        // Only the SE0 that follows chirp tones ends the chirp.
        if (chirp_seen && in_se0) next_state = ST_HS; // R3 R4
      end
      ST_HS: begin
        if (disc_port_flag) begin
          next_state = hold_s ? ST_DETACH : ST_FSLS; // R16 R17 R18
        end else if (idle_done) begin
          next_state = ST_SUSPEND; // R9
        end
      end
      ST_SUSPEND: begin
        if (out_se0) next_state = ST_CHIRP; // R11 R12
        else if (out_line == LINE_K) next_state = ST_RESUME; // R12
      end
      ST_RESUME: begin
        if (k_then_se0) next_state = ST_HS; // R13 R15
      end
      ST_DETACH: if (hold_done) next_state = ST_FSLS; // R18
      default: next_state = ST_RESET;
    endcase
    if (state != ST_RESET && state != ST_INITIAL && !en_s) begin
      next_state = ST_DISCONNECT; // R20
    end
  end

  // Timer restarts on every state change and on HS traffic.
  wire timer_clr = (next_state != state) || (in_hs && hs_act);

  // Chip reset skips the synchronisers so both paths stop at once.
  always_ff @(posedge clk_sys) begin
    if (reset || chip_in_reset) begin
      state <= ST_RESET; // R1
      timer <= '0;
      chirp_seen <= 1'b0;
      prev_out <= LINE_SE0;
    end else begin
      state <= next_state;
      timer <= timer_clr ? '0 : timer + CNT_W'(1);
      prev_out <= out_line;
      if (state != ST_CHIRP) chirp_seen <= 1'b0;
      else if (chirp_tone) chirp_seen <= 1'b1; // R3
    end
  end

  // SOF port memory survives suspend so resume restores it.
  always_ff @(posedge clk_sys) begin
    if (reset || chip_in_reset) begin
      sof_on_outer <= 1'b0;
    end else if (in_hs && in_sof) begin
      sof_on_outer <= 1'b0; // R8 R15
    end else if (in_hs && out_sof) begin
      sof_on_outer <= 1'b1; // R8 R15
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  wire paths_off = (next_state == ST_RESET) || (next_state == ST_DETACH);
  wire retime = (next_state == ST_HS);
  wire [1:0] next_path = paths_off ? PATH_OFF :
    (retime ? PATH_RETIME : PATH_SWITCH); // R6 R17
  wire next_oe = !paths_off; // R1 R18

  always_ff @(posedge clk_sys) begin
    if (reset || chip_in_reset) begin
      link.path_sel <= PATH_OFF; // R1
      link.outer_port_oe <= 1'b0; // R1
      link.inner_discon_en <= 1'b0;
      link.outer_discon_en <= 1'b0;
      link.state_code <= 4'h0;
    end else begin
      link.path_sel <= next_path;
      link.outer_port_oe <= next_oe;
      link.inner_discon_en <= retime && sof_on_outer; // R8
      link.outer_discon_en <= retime && !sof_on_outer; // R8
      link.state_code <= 4'(next_state);
    end
  end

endmodule // rpt_path_ctrl

// [rpt_partner.sv]
`timescale 1ns/1ns
// Purpose: Host-side partner driving enable and respecting host timing.
// Assumes: User requests arrive as one-cycle pulses.
// Notes: Gates SOF starts by the minimum gap after chirp or resume.
module rpt_partner
  import rpt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic user_enable,
  input wire logic user_detach_hold,
  input wire logic [1:0] user_inner_line,
  input wire logic [1:0] user_outer_line,
  input wire logic user_inner_hs,
  input wire logic user_outer_hs,
  input wire logic user_sof_req,
  input wire logic user_outer_sof,
  input wire logic user_disconnect,
  input wire logic user_detach_seen,
  output logic sof_sent,
  output logic hs_allowed,
  output logic [3:0] seen_state,
  rpt_link_if.partner link
);
  import rpt_pkg::*;

  logic [CNT_W-1:0] gap;
  logic [CNT_W-1:0] quiet;
  logic [3:0] last_state;
  wire entered_hs = (link.state_code == 4'(ST_HS)) &&
    (last_state != 4'(ST_HS));
  wire gap_ok = (gap >= CNT_W'(HOST_SOF_GAP_CYC)); // R5 R14
  wire quiet_ok = (quiet < CNT_W'(HOST_HS_QUIET_CYC)); // R10
  wire send = user_sof_req && gap_ok && quiet_ok;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      link.enable <= 1'b0;
      link.detach_hold <= 1'b0;
      link.inner_line <= LINE_SE0;
      link.outer_line <= LINE_SE0;
      link.inner_hs_activity <= 1'b0;
      link.outer_hs_activity <= 1'b0;
      link.inner_sof <= 1'b0;
      link.outer_sof <= 1'b0;
      link.disconnect_flag <= 1'b0;
      gap <= '0;
      quiet <= '0;
      last_state <= 4'h0;
      sof_sent <= 1'b0;
      hs_allowed <= 1'b0;
      seen_state <= 4'h0;
    end else begin
      link.enable <= user_enable && !user_detach_seen; // R19
      link.detach_hold <= user_detach_hold;
      link.inner_line <= user_inner_line;
      link.outer_line <= user_outer_line;
      link.inner_hs_activity <= user_inner_hs || send;
      link.outer_hs_activity <= user_outer_hs;
      link.inner_sof <= send && !user_outer_sof;
      link.outer_sof <= send && user_outer_sof;
      link.disconnect_flag <= user_disconnect;
      last_state <= link.state_code;
      if (entered_hs) gap <= '0;
      else if (!gap_ok) gap <= gap + CNT_W'(1);
      // Sending early keeps the repeater in HS for scheduling slack.
      if (send || user_inner_hs || user_outer_hs) quiet <= '0; // R7
      else if (quiet_ok) quiet <= quiet + CNT_W'(1);
      sof_sent <= send;
      hs_allowed <= gap_ok && quiet_ok;
      seen_state <= link.state_code;
    end
  end

endmodule // rpt_partner

// [rpt_path_checker.sv]
// Purpose: Concurrent checks on the repeater link as seen between both ends.
// Assumes: One clock; sync reset; state_code follows path_state_t.
// Notes: Timer bounds leave room for the two-flop input synchroniser.
`timescale 1ns/1ns
module rpt_path_checker #(
  parameter int unsigned IDLE_CYC = 50,
  parameter int unsigned HOLD_CYC = 50
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic active_low_chip_reset_n,
  input wire logic enable,
  input wire logic inner_hs_activity,
  input wire logic outer_hs_activity,
  input wire logic [1:0] path_sel,
  input wire logic outer_port_oe,
  input wire logic inner_discon_en,
  input wire logic outer_discon_en,
  input wire logic [3:0] state_code
);
  import rpt_pkg::*;
  logic [15:0] idle_cnt;
  logic [15:0] hold_cnt;
  wire in_hs = state_code == ST_HS;
  wire hs_quiet = in_hs && !inner_hs_activity && !outer_hs_activity;
  wire in_detach = state_code == ST_DETACH;
  // ----------------------------------------------------------------
  // Dwell counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    idle_cnt <= (reset || !hs_quiet) ? 16'h0 : idle_cnt + 16'h1;
    hold_cnt <= (reset || !in_detach) ? 16'h0 : hold_cnt + 16'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_reset_paths_off: assert property (
    !active_low_chip_reset_n |=> path_sel == PATH_OFF && !outer_port_oe)
    else $error("paths live during chip reset");
  a_fsls_switch: assert property (
    state_code == ST_FSLS |-> path_sel == PATH_SWITCH)
    else $error("full/low-speed state not on passthrough");
  a_hs_retime: assert property (in_hs |-> path_sel == PATH_RETIME)
    else $error("HS state not on re-timing path");
  a_one_detector: assert property (
    in_hs |-> inner_discon_en != outer_discon_en)
    else $error("detach detection not on exactly one port");
  a_idle_bound: assert property (idle_cnt <= IDLE_CYC + 6)
    else $error("HS kept too long without activity");
  a_suspend_switch: assert property (
    state_code inside {ST_SUSPEND, ST_RESUME} |-> path_sel == PATH_SWITCH)
    else $error("suspend or resume not on passthrough");
  a_detach_float: assert property (
    in_detach |-> path_sel == PATH_OFF && !outer_port_oe)
    else $error("detach hold not floating");
  a_hold_bound: assert property (hold_cnt <= HOLD_CYC + 2)
    else $error("detach hold too long");
  a_enable_drop: assert property (
    !enable && state_code > 4'h1 |-> ##[0:4] state_code == ST_DISCONNECT)
    else $error("enable low did not disconnect");
  a_disc_switch: assert property (
    state_code == ST_DISCONNECT |-> path_sel == PATH_SWITCH)
    else $error("disconnect state lost passthrough");
  c_hs: cover property (in_hs);
  c_resume: cover property (state_code == ST_RESUME);
  c_detach: cover property (in_detach);
endmodule // rpt_path_checker

// [tb.sv]
// Purpose: Drives both ends through attach, HS, suspend, resume and detach.
// Assumes: Timer parameters shortened to N cycles.
// Notes: Outer HS activity stays tied low; SOFs come on request.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import rpt_pkg::*;
  localparam int unsigned N = 50;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic chip_n = 1'b0;
  logic user_enable = 1'b0;
  logic user_detach_hold = 1'b0;
  logic [1:0] user_inner_line = LINE_J;
  logic [1:0] user_outer_line = LINE_J;
  logic user_inner_hs = 1'b0;
  logic user_disconnect = 1'b0;
  logic user_sof_req = 1'b0;
  logic user_outer_sof = 1'b0;
  logic user_detach_seen = 1'b0;
  logic sof_sent;
  logic hs_allowed;
  logic tie0 = 1'b0;
  int n_errors = 0;
  int checked = 0;
  rpt_link_if link();
  always #4 clk_sys = ~clk_sys;
  rpt_path_ctrl #(.INIT_CYC(N), .IDLE_CYC(N), .HOLD_CYC(N))
    rpt_path_ctrl_inst (.clk_sys(clk_sys), .reset(reset),
    .active_low_chip_reset_n(chip_n), .link(link.repeater));
  rpt_partner rpt_partner_inst (.clk_sys(clk_sys), .reset(reset),
    .user_enable(user_enable), .user_detach_hold(user_detach_hold),
    .user_inner_line(user_inner_line), .user_outer_line(user_outer_line),
    .user_inner_hs(user_inner_hs), .user_outer_hs(tie0),
    .user_sof_req(user_sof_req), .user_outer_sof(user_outer_sof),
    .user_disconnect(user_disconnect),
    .user_detach_seen(user_detach_seen),
    .sof_sent(sof_sent), .hs_allowed(hs_allowed), .seen_state(),
    .link(link.partner));
  rpt_path_checker #(.IDLE_CYC(N), .HOLD_CYC(N)) rpt_path_checker_inst (
    .clk_sys(clk_sys), .reset(reset), .active_low_chip_reset_n(chip_n),
    .enable(link.enable), .inner_hs_activity(link.inner_hs_activity),
    .outer_hs_activity(link.outer_hs_activity), .path_sel(link.path_sel),
    .outer_port_oe(link.outer_port_oe),
    .inner_discon_en(link.inner_discon_en),
    .outer_discon_en(link.outer_discon_en),
    .state_code(link.state_code));
  task automatic report_and_stop;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Samples at the falling edge so registered outputs have settled.
  task automatic wait_st(input path_state_t s, input logic [1:0] p);
    int i;
    @(negedge clk_sys);
    for (i = 0; i < 300 && link.state_code !== s; i++) @(negedge clk_sys);
    `CHK(link.state_code, s)
    `CHK(link.path_sel, p)
  endtask
  task automatic in_line(input logic [1:0] v);
    @(posedge clk_sys);
    user_inner_line <= v;
    repeat (6) @(posedge clk_sys);
  endtask
  // One SOF request; exp says whether the host gap lets it out.
  task automatic sof(input logic outer, input logic exp);
    @(posedge clk_sys);
    user_sof_req <= 1'b1;
    user_outer_sof <= outer;
    @(posedge clk_sys);
    user_sof_req <= 1'b0;
    @(negedge clk_sys);
    `CHK(outer ? link.outer_sof : link.inner_sof, exp)
    `CHK(sof_sent, exp)
    `CHK(hs_allowed, exp)
  endtask
  task automatic to_hs;
    in_line(LINE_SE0);
    wait_st(ST_CHIRP, PATH_SWITCH);
    in_line(LINE_K);
    in_line(LINE_J);
    @(negedge clk_sys);
    `CHK(link.state_code, ST_CHIRP)
    in_line(LINE_SE0);
    wait_st(ST_HS, PATH_RETIME);
    @(posedge clk_sys);
    user_inner_line <= LINE_J;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK(link.state_code, ST_RESET)
    `CHK(link.outer_port_oe, 1'b0)
    @(posedge clk_sys);
    chip_n <= 1'b1;
    wait_st(ST_DISCONNECT, PATH_SWITCH);
    @(posedge clk_sys);
    user_enable <= 1'b1;
    wait_st(ST_FSLS, PATH_SWITCH);
    to_hs();
    user_inner_hs <= 1'b1;
    sof(1'b0, 1'b0);
    repeat (HOST_SOF_GAP_CYC + 16) @(posedge clk_sys);
    sof(1'b0, 1'b1);
    `CHK(link.outer_discon_en, 1'b1)
    sof(1'b1, 1'b1);
    repeat (2 * N) @(negedge clk_sys);
    `CHK(link.state_code, ST_HS)
    `CHK(link.outer_discon_en, 1'b0)
    `CHK(link.inner_discon_en, 1'b1)
    @(posedge clk_sys);
    user_inner_hs <= 1'b0;
    wait_st(ST_SUSPEND, PATH_SWITCH);
    @(posedge clk_sys);
    user_outer_line <= LINE_K;
    wait_st(ST_RESUME, PATH_SWITCH);
    @(posedge clk_sys);
    user_outer_line <= LINE_SE0;
    wait_st(ST_HS, PATH_RETIME);
    `CHK(link.inner_discon_en, 1'b1)
    `CHK(link.outer_discon_en, 1'b0)
    sof(1'b0, 1'b0);
    @(posedge clk_sys);
    user_outer_line <= LINE_J;
    user_disconnect <= 1'b1;
    wait_st(ST_FSLS, PATH_SWITCH);
    @(posedge clk_sys);
    user_disconnect <= 1'b0;
    user_detach_hold <= 1'b1;
    to_hs();
    user_disconnect <= 1'b1;
    wait_st(ST_DETACH, PATH_OFF);
    `CHK(link.outer_port_oe, 1'b0)
    @(posedge clk_sys);
    user_disconnect <= 1'b0;
    wait_st(ST_FSLS, PATH_SWITCH);
    @(posedge clk_sys);
    user_detach_seen <= 1'b1;
    wait_st(ST_DISCONNECT, PATH_SWITCH);
    `CHK(link.enable, 1'b0)
    @(posedge clk_sys);
    user_detach_seen <= 1'b0;
    wait_st(ST_FSLS, PATH_SWITCH);
    to_hs();
    wait_st(ST_SUSPEND, PATH_SWITCH);
    @(posedge clk_sys);
    user_outer_line <= LINE_SE0;
    wait_st(ST_CHIRP, PATH_SWITCH);
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    report_and_stop();
  end
endmodule // tb
